// >>> hdl/boot_strap_mode_decoder.sv
/*
  Boot strap mode decoder: captures boot mode and 32 configuration straps at
  power-on reset release, decodes boot options and walks a simple boot flow.
  Assumes one 40 MHz clock, inputs synchronous to it, and that the boot loader
  outside reports load completion and errors through plain status inputs.
*/
module boot_strap_mode_decoder (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_on_reset_n,
  input wire logic [1:0] boot_mode_pins,
  input wire logic [31:0] shared_addr_data_line,
  input wire logic init_done,
  input wire logic image_loaded,
  input wire logic [31:0] image_entry,
  input wire logic boot_error,
  output logic straps_valid,
  output logic [1:0] boot_mode,
  output logic [7:0] strap_group_one,
  output logic [7:0] strap_group_two,
  output logic [7:0] strap_group_three,
  output logic [7:0] strap_group_four,
  output logic [1:0] boot_flow,
  output logic [2:0] boot_device,
  output logic icache_enable,
  output logic mmu_caches_enable,
  output logic [9:0] core_mhz,
  output logic [9:0] mem_mhz,
  output logic [9:0] bus_mhz,
  output logic serial_nor_default,
  output logic load_request,
  output logic branch_valid,
  output logic [31:0] branch_addr,
  output logic downloader_active
);
  // ------------------------------------------------------------
  // reset release detection and strap capture
  // ------------------------------------------------------------
  logic por_seen_reg;
  logic por_seen_next;
  logic capture_pulse;
  logic [33:0] held;
  logic [31:0] straps;
  logic [1:0] mode_cap;

  always_comb begin
    por_seen_next = power_on_reset_n;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      por_seen_reg <= 1'b0;
    end else begin
      por_seen_reg <= por_seen_next;
    end
  end

  // rising edge of the power-on reset marks the single capture point
  assign capture_pulse = power_on_reset_n & ~por_seen_reg;

  strap_capture #(
    .width(34)
  ) u_capture (
    .sys_clk(sys_clk),
    .rst(rst),
    .capture(capture_pulse),
    .pins({boot_mode_pins, shared_addr_data_line}),
    .held(held)
  );

  assign straps = held[31:0];
  assign mode_cap = held[33:32];

  // ------------------------------------------------------------
  // boot flow state machine
  // ------------------------------------------------------------
  boot_strap_pkg::boot_state_type state_reg;
  boot_strap_pkg::boot_state_type state_next;
  logic [31:0] entry_reg;
  logic [31:0] entry_next;

  always_comb begin
    state_next = state_reg;
    entry_next = entry_reg;
    if (!power_on_reset_n) begin
      state_next = boot_strap_pkg::st_reset;
    end else begin
      case (state_reg)
        boot_strap_pkg::st_reset: begin
          if (capture_pulse) begin
            state_next = boot_strap_pkg::st_capture;
          end
        end
        boot_strap_pkg::st_capture: begin
          case (mode_cap)
            boot_strap_pkg::mode_fuse: state_next = boot_strap_pkg::st_fuse;
            boot_strap_pkg::mode_downloader: state_next = boot_strap_pkg::st_downloader;
            boot_strap_pkg::mode_internal: state_next = boot_strap_pkg::st_init;
            default: state_next = boot_strap_pkg::st_halt;
          endcase
        end
        boot_strap_pkg::st_init: begin
          if (boot_error) begin
            state_next = boot_strap_pkg::st_downloader;
          end else if (init_done) begin
            state_next = boot_strap_pkg::st_load;
          end
        end
        boot_strap_pkg::st_load: begin
          if (boot_error) begin
            state_next = boot_strap_pkg::st_downloader;
          end else if (image_loaded) begin
            entry_next = image_entry;
            state_next = boot_strap_pkg::st_branch;
          end
        end
        boot_strap_pkg::st_branch: state_next = boot_strap_pkg::st_branch;
        boot_strap_pkg::st_downloader: state_next = boot_strap_pkg::st_downloader;
        boot_strap_pkg::st_fuse: state_next = boot_strap_pkg::st_fuse;
        boot_strap_pkg::st_halt: state_next = boot_strap_pkg::st_halt;
        default: state_next = boot_strap_pkg::st_reset;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= boot_strap_pkg::st_reset;
      entry_reg <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
      entry_reg <= entry_next;
    end
  end

  // ------------------------------------------------------------
  // strap decode
  // ------------------------------------------------------------
  logic [7:0] g1;
  logic [7:0] g3;
  logic [4:0] dev_sel;
  boot_strap_pkg::boot_device_type dev_dec;
  logic [1:0] flow_dec;
  logic fast_clk;

  assign g1 = straps[boot_strap_pkg::group_one_lsb +: boot_strap_pkg::group_width];
  assign g3 = straps[boot_strap_pkg::group_three_lsb +: boot_strap_pkg::group_width];
  assign dev_sel = g1[boot_strap_pkg::device_sel_msb:boot_strap_pkg::device_sel_lsb];
  assign fast_clk = ~g3[boot_strap_pkg::clock_set_bit];

  always_comb begin
    if (dev_sel[4]) begin
      dev_dec = boot_strap_pkg::dev_nand_flash;
    end else if (dev_sel[3:2] == 2'h3) begin
      dev_dec = boot_strap_pkg::dev_mmc;
    end else if (dev_sel[3:2] == 2'h2) begin
      dev_dec = boot_strap_pkg::dev_sd;
    end else if (dev_sel[3:1] == 3'h3) begin
      dev_dec = boot_strap_pkg::dev_serial_rom;
    end else if (dev_sel[3:1] == 3'h2) begin
      dev_dec = boot_strap_pkg::dev_serial_ata;
    end else if (dev_sel[0]) begin
      dev_dec = boot_strap_pkg::dev_parallel_nand;
    end else begin
      dev_dec = boot_strap_pkg::dev_parallel_nor;
    end
  end

  always_comb begin
    case (mode_cap)
      boot_strap_pkg::mode_fuse: flow_dec = boot_strap_pkg::flow_fuse;
      boot_strap_pkg::mode_downloader: flow_dec = boot_strap_pkg::flow_downloader;
      boot_strap_pkg::mode_internal: flow_dec = boot_strap_pkg::flow_internal;
      default: flow_dec = boot_strap_pkg::flow_reserved;
    endcase
  end

  // ------------------------------------------------------------
  // output registers
  // ------------------------------------------------------------
  logic valid_reg;
  logic default_match;

  // the on-module defaults select serial nor on port five, cs0, 3-byte address
  assign default_match = (mode_cap == boot_strap_pkg::default_mode)
    && (straps == {boot_strap_pkg::default_group_four, boot_strap_pkg::default_group_three,
                   boot_strap_pkg::default_group_two, boot_strap_pkg::default_group_one});

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      valid_reg <= 1'b0;
      straps_valid <= 1'b0;
      boot_mode <= 2'h0;
      strap_group_one <= 8'h00;
      strap_group_two <= 8'h00;
      strap_group_three <= 8'h00;
      strap_group_four <= 8'h00;
      boot_flow <= 2'h0;
      boot_device <= 3'h0;
      icache_enable <= 1'b0;
      mmu_caches_enable <= 1'b0;
      core_mhz <= 10'h000;
      mem_mhz <= 10'h000;
      bus_mhz <= 10'h000;
      serial_nor_default <= 1'b0;
      load_request <= 1'b0;
      branch_valid <= 1'b0;
      branch_addr <= 32'h0000_0000;
      downloader_active <= 1'b0;
    end else begin
      valid_reg <= power_on_reset_n & (valid_reg | capture_pulse);
      straps_valid <= valid_reg;
      boot_mode <= mode_cap;
      strap_group_one <= g1;
      strap_group_two <= straps[boot_strap_pkg::group_two_lsb +: boot_strap_pkg::group_width];
      strap_group_three <= g3;
      strap_group_four <= straps[boot_strap_pkg::group_four_lsb +: boot_strap_pkg::group_width];
      boot_flow <= flow_dec;
      boot_device <= dev_dec;
      icache_enable <= ~g3[boot_strap_pkg::icache_off_bit];
      mmu_caches_enable <= ~g3[boot_strap_pkg::mmu_off_bit];
      core_mhz <= fast_clk ? boot_strap_pkg::fast_core_mhz : boot_strap_pkg::slow_core_mhz;
      mem_mhz <= fast_clk ? boot_strap_pkg::fast_mem_mhz : boot_strap_pkg::slow_mem_mhz;
      bus_mhz <= fast_clk ? boot_strap_pkg::fast_bus_mhz : boot_strap_pkg::slow_bus_mhz;
      serial_nor_default <= default_match;
      load_request <= (state_reg == boot_strap_pkg::st_load);
      branch_valid <= (state_reg == boot_strap_pkg::st_branch);
      branch_addr <= entry_reg;
      downloader_active <= (state_reg == boot_strap_pkg::st_downloader);
    end
  end
endmodule

// >>> pkg/boot_strap_pkg.sv
/*
  Constants, types and encodings for the boot strap mode decoder.
  Assumes one clock domain (sys_clk, 40 MHz) and straps that are static around reset release.
*/
package boot_strap_pkg;
  // ------------------------------------------------------------
  // boot mode field
  // ------------------------------------------------------------
  localparam logic [1:0] mode_fuse = 2'h0;
  localparam logic [1:0] mode_downloader = 2'h1;
  localparam logic [1:0] mode_internal = 2'h2;
  localparam logic [1:0] mode_reserved = 2'h3;

  // ------------------------------------------------------------
  // strap layout
  // ------------------------------------------------------------
  localparam int strap_width = 32;
  localparam int group_width = 8;
  localparam int group_one_lsb = 0;
  localparam int group_two_lsb = 8;
  localparam int group_three_lsb = 16;
  localparam int group_four_lsb = 24;
  localparam int icache_off_bit = 7;
  localparam int mmu_off_bit = 6;
  localparam int clock_set_bit = 2;
  localparam int device_sel_msb = 7;
  localparam int device_sel_lsb = 3;

  // ------------------------------------------------------------
  // on-module default values
  // ------------------------------------------------------------
  localparam logic [1:0] default_mode = 2'h2;
  localparam logic [7:0] default_group_one = 8'h33;
  localparam logic [7:0] default_group_two = 8'hdd;
  localparam logic [7:0] default_group_three = 8'hc8;
  localparam logic [7:0] default_group_four = 8'h4c;

  // ------------------------------------------------------------
  // clock sets in MHz
  // ------------------------------------------------------------
  localparam logic [9:0] fast_core_mhz = 10'd792;
  localparam logic [9:0] fast_mem_mhz = 10'd532;
  localparam logic [9:0] fast_bus_mhz = 10'd264;
  localparam logic [9:0] slow_core_mhz = 10'd396;
  localparam logic [9:0] slow_mem_mhz = 10'd352;
  localparam logic [9:0] slow_bus_mhz = 10'd176;

  // ------------------------------------------------------------
  // boot device codes and sequence states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    dev_parallel_nor, dev_parallel_nand, dev_serial_ata, dev_serial_rom,
    dev_sd, dev_mmc, dev_nand_flash
  } boot_device_type;

  typedef enum logic [1:0] {
    flow_fuse, flow_downloader, flow_internal, flow_reserved
  } boot_flow_type;

  typedef enum {
    st_reset, st_capture, st_init, st_load, st_branch, st_downloader, st_fuse, st_halt
  } boot_state_type;
endpackage

// >>> hdl/strap_capture.sv
/*
  Strap capture register: samples the shared address/data lines and boot mode pins
  on the first clock after power-on reset release, then holds them.
  Assumes power_on_reset_n is synchronous to sys_clk.
*/
module strap_capture #(
  parameter int width = 34
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic capture,
  input wire logic [width-1:0] pins,
  output logic [width-1:0] held
);
  logic [width-1:0] held_reg;
  logic [width-1:0] held_next;

  always_comb begin
    held_next = held_reg;
    if (capture) begin
      held_next = pins;
    end
  end

  // reset value is a constant; the pin value is only taken on the clock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      held_reg <= '0;
    end else begin
      held_reg <= held_next;
    end
  end

  assign held = held_reg;
endmodule

// >>> dv/strap_network_model.sv
/*
  Carrier-board strap resistor network beside the module's own defaults.
  Assumes the testbench picks which straps a fitted resistor overrides.
*/
module strap_network_model (
  input wire logic sys_clk,
  input wire logic bus_active,
  input wire logic [33:0] fit_en,
  input wire logic [33:0] fit_up,
  output logic [1:0] boot_mode_pins,
  output logic [31:0] shared_addr_data_line
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // strap levels and shared line traffic
  // ------------------------------------------------------------
  logic [33:0] strap;
  logic [31:0] traffic = 32'h0;
  // on-module levels laid out as {mode, group four, three, two, one}
  always_comb strap = (34'h2_4cc8_dd33 & ~fit_en) | (fit_up & fit_en);
  // once the bus runs, the lines carry changing traffic, not the straps
  always @(posedge sys_clk) traffic <= ~traffic + 32'h9e3779b9;
  assign shared_addr_data_line = bus_active ? traffic : strap[31:0];
  assign boot_mode_pins = strap[33:32];
endmodule

// >>> dv/boot_strap_mode_decoder_sva.sv
/*
  Checker for the boot strap decoder, bound to its top module.
  Assumes power_on_reset_n is held low while rst is high.
*/
module boot_strap_mode_decoder_sva (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_on_reset_n,
  input wire logic [1:0] boot_mode_pins,
  input wire logic [31:0] shared_addr_data_line,
  input wire logic image_loaded,
  input wire logic [31:0] image_entry,
  input wire logic boot_error,
  input wire logic straps_valid,
  input wire logic [1:0] boot_mode,
  input wire logic [7:0] strap_group_one,
  input wire logic [7:0] strap_group_two,
  input wire logic [7:0] strap_group_three,
  input wire logic [7:0] strap_group_four,
  input wire logic [2:0] boot_device,
  input wire logic icache_enable,
  input wire logic mmu_caches_enable,
  input wire logic [9:0] core_mhz,
  input wire logic serial_nor_default,
  input wire logic load_request,
  input wire logic branch_valid,
  input wire logic [31:0] branch_addr,
  input wire logic downloader_active
);
  timeunit 1ns;
  timeprecision 100ps;
  // ------------------------------------------------------------
  // helpers and assertions
  // ------------------------------------------------------------
  logic [33:0] cap;
  logic [7:0] g1;
  logic [2:0] dev_exp;
  assign cap = {boot_mode, strap_group_four, strap_group_three, strap_group_two, strap_group_one};
  assign g1 = strap_group_one;
  always_comb begin
    if (g1[7]) dev_exp = 3'h6;
    else if (g1[6]) dev_exp = g1[5] ? 3'h5 : 3'h4;
    else if (g1[5]) dev_exp = g1[4] ? 3'h3 : 3'h2;
    else dev_exp = {2'h0, g1[3]};
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_capture_at_release: assert property (
    $rose(power_on_reset_n) |-> ##2 straps_valid && cap == $past({boot_mode_pins,
    shared_addr_data_line}, 2)) else $error("captured straps differ from pins");
  a_captured_held: assert property (
    straps_valid && $past(straps_valid) |-> $stable(cap)) else $error("straps moved");
  a_icache_decode: assert property (
    straps_valid |-> icache_enable == !strap_group_three[7]) else $error("icache bad");
  a_mmu_decode: assert property (
    straps_valid |-> mmu_caches_enable == !strap_group_three[6]) else $error("mmu bad");
  a_clock_set: assert property (
    straps_valid |-> core_mhz == (strap_group_three[2] ? boot_strap_pkg::slow_core_mhz :
    boot_strap_pkg::fast_core_mhz)) else $error("core clock bad");
  a_device_decode: assert property (
    straps_valid |-> boot_device == dev_exp) else $error("boot device bad");
  a_default_flag: assert property (
    straps_valid |-> serial_nor_default == (cap == 34'h24cc8dd33)) else $error("default bad");
  a_downloader_mode: assert property (
    $rose(straps_valid) && boot_mode == boot_strap_pkg::mode_downloader |-> ##[0:3]
    downloader_active) else $error("downloader not entered");
  a_no_load_other: assert property (
    straps_valid && boot_mode[0] |-> !load_request && !branch_valid) else $error("load bad");
  a_branch_entry: assert property (
    image_loaded && load_request |-> ##[1:2] branch_valid && branch_addr == image_entry)
    else $error("branch missing");
  a_error_fallback: assert property (
    boot_error && load_request |-> ##[1:3] downloader_active) else $error("no fallback");
  c_branch: cover property (branch_valid);
  c_fallback: cover property (boot_error && downloader_active);
  c_default: cover property (serial_nor_default);
endmodule

bind boot_strap_mode_decoder boot_strap_mode_decoder_sva chk (.*);

// >>> dv/tb.sv
/*
  Self-checking bench for the boot strap decoder with a strap network model.
  Assumes the decoder's hand-over latencies: outputs one edge after the capture edge, two edges after release.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic power_on_reset_n = 1'b0;
  logic init_done = 1'b0, image_loaded = 1'b0, boot_error = 1'b0, bus_active = 1'b0;
  logic [31:0] image_entry = 32'h10008000;
  logic [33:0] fit_en = '0, fit_up = '0;
  logic [1:0] boot_mode_pins, boot_mode, boot_flow;
  logic [31:0] shared_addr_data_line, branch_addr;
  logic straps_valid, icache_enable, mmu_caches_enable, serial_nor_default;
  logic load_request, branch_valid, downloader_active;
  logic [7:0] strap_group_one, strap_group_two, strap_group_three, strap_group_four;
  logic [2:0] boot_device;
  logic [9:0] core_mhz, mem_mhz, bus_mhz;
  int n_mismatch = 0, check_count = 0;
  boot_strap_mode_decoder DUT (.*);
  strap_network_model straps (.*);
  always #12.5 sys_clk = ~sys_clk;
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // bus traffic starts right after the capture edge, so late sampling shows up
  task power_up(input logic [33:0] en, input logic [33:0] up);
    {init_done, image_loaded, boot_error, bus_active} = 4'h0;
    fit_en = en;
    fit_up = up;
    power_on_reset_n = 1'b0;
    step(3);
    power_on_reset_n = 1'b1;
    step(1);
    bus_active = 1'b1;
    step(2);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task run_defaults;
    power_up('0, '0);
    check("valid", straps_valid, 1'b1);
    check("flow", boot_flow, 2'h2);
    check("mode", boot_mode, 2'h2);
    check("groups", {strap_group_one, strap_group_two, strap_group_three,
      strap_group_four}, 32'h33ddc84c);
    check("nor default", serial_nor_default, 1'b1);
    check("device", boot_device, 3'h3);
    init_done = 1'b1;
    step(2);
    check("load request", load_request, 1'b1);
    init_done = 1'b0;
    image_loaded = 1'b1;
    step(4);
    check("branch valid", branch_valid, 1'b1);
    check("branch addr", branch_addr, image_entry);
    check("held groups", {strap_group_four, strap_group_one}, 16'h4c33);
  endtask
  task run_devices;
    logic [4:0] sel [7];
    logic [33:0] up;
    sel = '{5'h00, 5'h01, 5'h05, 5'h07, 5'h0b, 5'h0e, 5'h1f};
    for (int i = 0; i < 7; i++) begin
      up = '0;
      up[7:3] = sel[i];
      up[23] = i[0];
      up[22] = i[1];
      up[18] = i[2];
      power_up(34'h000c400f8, up);
      check("device", boot_device, i);
      check("icache", icache_enable, !i[0]);
      check("mmu", mmu_caches_enable, !i[1]);
      check("core", core_mhz, i[2] ? 10'h18c : 10'h318);
      check("mem", mem_mhz, i[2] ? 10'h160 : 10'h214);
      check("bus", bus_mhz, i[2] ? 10'h0b0 : 10'h108);
      check("not default", serial_nor_default, 1'b0);
    end
  endtask
  task run_modes;
    for (int m = 0; m < 4; m++) begin
      if (m != 2) begin
        power_up(34'h300000000, {m[1:0], 32'h0});
        step(3);
        check("flow", boot_flow, m);
        check("downloader", downloader_active, m == 1);
        check("no load", load_request, 1'b0);
      end
    end
  endtask
  task run_error;
    power_up('0, '0);
    init_done = 1'b1;
    step(2);
    boot_error = 1'b1;
    step(3);
    check("fallback", downloader_active, 1'b1);
    check("load stopped", {load_request, branch_valid}, 2'h0);
  endtask
  task run_reset;
    rst = 1'b1;
    step(1);
    check("valid in reset", straps_valid, 1'b0);
    check("mode in reset", boot_mode, 2'h0);
    rst = 1'b0;
    step(1);
  endtask
  initial begin
    step(4);
    rst = 1'b0;
    step(1);
    run_defaults;
    run_devices;
    run_modes;
    run_error;
    run_reset;
    run_defaults;
    print_verdict;
  end
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
endmodule
